// >>> hw/kbc_map.vh
// Notes on behaviour
// R01: Core write of mailbox loads host read buffer, sets output full, raises irq if enabled.
// R02: Core read returns last host written byte and clears input full.
// R03: Status register clears on reset; host reads only, core reads and writes.
// R04: Status bits 7..4 and 2 are user bits written only by core.
// R05: Status bit 3 marks command or data, loaded from host address bit 2.
// R06: Host write sets input full and core interrupt; core read clears both.
// R07: Core write sets output full; host read of data clears it.
// R08: Reset source holds reset at least 24 periods of 16 MHz.
// R09: Block runs on a single clock derived externally; no clock loading logic here.
// R10: Reset releases keyboard and mouse lines to inputs and zeroes status.
// R11: Fast gate port answers host only when configuration bit 2 is set.
// R12: Fast gate port reserved bits read fixed 00, 1, 0, 0, 1.
// R13: Writing port bit 1 sets alternate address gate level.
// R14: Writing 1 to port bit 0 pulses alternate reset low after 14 us for 6 us.
// R15: Bit 0 must return to 0 before another pulse; rewriting 1 does not retrigger.
// R16: Reset clears port bit 0 and holds alternate reset high.
// R17: Enabled alternate reset ANDed with controller reset pulse, polarity selectable, to pin.
// R18: Address mask output low only when gate port bit and alternate gate both low.
// R19: Reset drives alternate address gate low.
// R20: Host data address write clears command flag; command address write sets it.
// R21: With flag gating and irq port bit set, output full drives keyboard irq; else low. Without flag gating the code drives the irq port bit level instead.
// R22: Disabled fast gate port ignores host writes and does not drive data bus.
`ifndef KBC_MAP_VH
`define KBC_MAP_VH
`define KBC_ADDR_DATA        16'h0060
`define KBC_ADDR_CMD         16'h0064
`define KBC_ADDR_FAST        16'h0092
`define KBC_FAST_RESET       8'h24
`define KBC_FAST_FIXED       8'h24
`define KBC_STATUS_RESET     8'h00
`define KBC_BIT_OUTFULL      0
`define KBC_BIT_INFULL       1
`define KBC_BIT_CMD          3
`define KBC_USER_MASK        8'hF4
`define KBC_CFG_FAST_EN      2
`define KBC_CLK_MHZ          20
`define KBC_DELAY_NS         14000
`define KBC_WIDTH_NS         6000
`define KBC_DELAY_CYC        ((`KBC_DELAY_NS * `KBC_CLK_MHZ + 999) / 1000)
`define KBC_WIDTH_CYC        ((`KBC_WIDTH_NS * `KBC_CLK_MHZ + 999) / 1000)
`endif

// >>> hw/kbc_sync3.v
`timescale 1ns/1ps
`default_nettype none
// -----------------------------------------------------------------------------
// Three stage synchroniser with agreement filter
// -----------------------------------------------------------------------------
module kbc_sync3 (
    // Clock and reset.
    input  wire clk,
    input  wire nrst,
    // Asynchronous level in, filtered level out.
    input  wire asyncIn,
    output reg  syncOut
);
    reg s1Q;
    reg s2Q;
    reg s3Q;

    // The first stage feeds only the second; output moves when stages two and three agree.
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s1Q     <= 1'b0;
            s2Q     <= 1'b0;
            s3Q     <= 1'b0;
            syncOut <= 1'b0;
        end else begin
            s1Q <= asyncIn;
            s2Q <= s1Q;
            s3Q <= s2Q;
            if (s2Q == s3Q) begin
                syncOut <= s3Q;
            end
        end
    end
endmodule // kbc_sync3
`default_nettype wire

// >>> hw/kbc_pulse_gen.v
`timescale 1ns/1ps
`default_nettype none
`include "kbc_map.vh"
// -----------------------------------------------------------------------------
// Alternate reset pulse timer
// -----------------------------------------------------------------------------
module kbc_pulse_gen (
    // Clock and reset.
    input  wire clk,
    input  wire nrst,
    // One-cycle start request.
    input  wire start,
    // Active-low reset pulse, registered.
    output reg  pulseN
);
    localparam [2:0] ST_IDLE  = 3'b001;
    localparam [2:0] ST_DELAY = 3'b010;
    localparam [2:0] ST_PULSE = 3'b100;
    // Counts are worked out as integers, then cut to the counter width on purpose.
    localparam integer DELAY_LAST_I = `KBC_DELAY_CYC - 1;
    localparam integer WIDTH_LAST_I = `KBC_WIDTH_CYC - 1;
    localparam [9:0]   DELAY_LAST   = DELAY_LAST_I[9:0];
    localparam [9:0]   WIDTH_LAST   = WIDTH_LAST_I[9:0];

    reg [2:0] stateQ;
    reg [9:0] cntQ;

    // Wait the delay, then hold the pulse low for the width; a start mid-pulse is dropped.
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            stateQ <= ST_IDLE;
            cntQ   <= 10'h000;
            pulseN <= 1'b1; // see R16
        end else begin
            case (stateQ)
                ST_IDLE: begin
                    cntQ <= 10'h000;
                    if (start) begin
                        stateQ <= ST_DELAY;
                    end
                end
                ST_DELAY: begin
                    if (cntQ == DELAY_LAST) begin // see R14
                        cntQ   <= 10'h000;
                        pulseN <= 1'b0;
                        stateQ <= ST_PULSE;
                    end else begin
                        cntQ <= cntQ + 10'h001;
                    end
                end
                ST_PULSE: begin
                    if (cntQ == WIDTH_LAST) begin // see R14
                        pulseN <= 1'b1;
                        stateQ <= ST_IDLE;
                    end else begin
                        cntQ <= cntQ + 10'h001;
                    end
                end
                default: begin
                    stateQ <= ST_IDLE;
                    pulseN <= 1'b1;
                end
            endcase
        end
    end
endmodule // kbc_pulse_gen
`default_nettype wire

// >>> hw/kbc_host_port.v
`timescale 1ns/1ps
`default_nettype none
`include "kbc_map.vh"
// -----------------------------------------------------------------------------
// Host mailbox, fast gate port and reset logic
// -----------------------------------------------------------------------------
module kbc_host_port (
    // Clock and reset.
    input  wire       clk,  // Single clock from outside; no clock loading logic here, see R09
    input  wire       nrst,
    // Host I/O bus, pins from outside this clock domain.
    input  wire [15:0] hostAddr,
    input  wire        hostRdN,
    input  wire        hostWrN,
    input  wire [7:0]  hostDataIn,
    output reg  [7:0]  hostDataOut,
    output reg         hostDataOe,
    // Controller core side, same clock, one-cycle strobes.
    input  wire        coreDataWr,
    input  wire        coreDataRd,
    input  wire        coreStatusWr,
    input  wire [7:0]  coreDataIn,
    output reg  [7:0]  coreMailboxBuffer,
    output reg  [7:0]  coreStatus,
    output reg         coreInputFullInterrupt,
    input  wire        coreIbfIrqEnable,
    // Controller core port bits and flag mode.
    input  wire        enableFlags,
    input  wire        keyboardIrqPortBit,
    input  wire        controllerGatePortBit,
    input  wire        controllerResetPulse,
    // Configuration.
    input  wire [7:0]  fastPortConfig,
    input  wire        resetPolarityInvert,
    // System outputs.
    output reg         keyboardInterrupt,
    output reg         cpuAddrMaskOut,
    output reg         alternateAddressGate,
    output reg         alternateResetOut,
    output reg         keyboardResetPin,
    // Keyboard and mouse open-drain lines, enables high while driving low.
    output reg         keyboardClockOe,
    output reg         keyboardDataOe,
    output reg         mouseClockOe,
    output reg         mouseDataOe
);
    // -------------------------------------------------------------------------
    // Host strobe synchronisation
    // -------------------------------------------------------------------------
    wire rdSync;
    wire wrSync;
    reg  rdPrevQ;
    reg  wrPrevQ;

    // Strobes are active low on the pins; synchronise their active sense.
    kbc_sync3 u_syncRd (
        .clk     (clk),
        .nrst    (nrst),
        .asyncIn (~hostRdN),
        .syncOut (rdSync)
    );
    kbc_sync3 u_syncWr (
        .clk     (clk),
        .nrst    (nrst),
        .asyncIn (~hostWrN),
        .syncOut (wrSync)
    );

    // Edge memory so each host cycle acts once.
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rdPrevQ <= 1'b0;
            wrPrevQ <= 1'b0;
        end else begin
            rdPrevQ <= rdSync;
            wrPrevQ <= wrSync;
        end
    end

    // Address and data are assumed stable by the time the filtered strobe has settled.
    wire hostRdStart = rdSync & ~rdPrevQ;
    wire hostWrStart = wrSync & ~wrPrevQ;
    wire selData     = (hostAddr == `KBC_ADDR_DATA);
    wire selCmd      = (hostAddr == `KBC_ADDR_CMD);
    wire fastEn      = fastPortConfig[`KBC_CFG_FAST_EN];
    wire selFast     = (hostAddr == `KBC_ADDR_FAST) & fastEn; // see R11 R22

    // -------------------------------------------------------------------------
    // Mailbox registers
    // -------------------------------------------------------------------------
    reg [7:0] hostReadBufQ;
    reg [7:0] hostWriteBufQ;
    reg [7:0] statusQ;
    reg [7:0] fastPortQ;

    // Data buffers have no defined reset value; kept unreset to match the part.
    always @(posedge clk) begin
        if (coreDataWr) begin
            hostReadBufQ <= coreDataIn; // see R01
        end
        if (hostWrStart && (selData || selCmd)) begin
            hostWriteBufQ <= hostDataIn;
        end
    end

    // Status: host events win over core clears in the same cycle.
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            statusQ <= `KBC_STATUS_RESET; // see R03 R10
        end else begin
            if (coreStatusWr) begin
                statusQ <= (statusQ & ~`KBC_USER_MASK) | (coreDataIn & `KBC_USER_MASK); // see R04
            end
            if (coreDataRd) begin
                statusQ[`KBC_BIT_INFULL] <= 1'b0; // see R02 R06
            end
            if (hostRdStart && selData) begin
                statusQ[`KBC_BIT_OUTFULL] <= 1'b0; // see R07
            end
            if (coreDataWr) begin
                statusQ[`KBC_BIT_OUTFULL] <= 1'b1; // see R01 R07
            end
            if (hostWrStart && (selData || selCmd)) begin
                statusQ[`KBC_BIT_INFULL] <= 1'b1;        // see R06 R20
                statusQ[`KBC_BIT_CMD]    <= hostAddr[2]; // see R05 R20
            end
        end
    end

    // -------------------------------------------------------------------------
    // Fast gate port
    // -------------------------------------------------------------------------
    reg  altStartQ;

    // Only bits 1 and 0 are stored; a pulse starts on a 0 to 1 change of bit 0.
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            fastPortQ <= `KBC_FAST_RESET; // see R16 R19
            altStartQ <= 1'b0;
        end else begin
            altStartQ <= 1'b0;
            if (hostWrStart && selFast) begin // see R22
                fastPortQ <= `KBC_FAST_FIXED | {6'h00, hostDataIn[1:0]}; // see R13
                altStartQ <= hostDataIn[0] & ~fastPortQ[0]; // see R15
            end
        end
    end

    wire altPulseN;

    kbc_pulse_gen u_pulse (
        .clk    (clk),
        .nrst   (nrst),
        .start  (altStartQ),
        .pulseN (altPulseN)
    );

    // -------------------------------------------------------------------------
    // Host read data and bus drive
    // -------------------------------------------------------------------------
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            hostDataOut <= 8'h00;
            hostDataOe  <= 1'b0;
        end else begin
            hostDataOe <= rdSync & (selData | selCmd | selFast); // see R22
            if (selData) begin
                hostDataOut <= hostReadBufQ;
            end else if (selCmd) begin
                hostDataOut <= statusQ;
            end else if (selFast) begin
                hostDataOut <= `KBC_FAST_FIXED | {6'h00, fastPortQ[1:0]}; // see R12
            end else begin
                hostDataOut <= 8'h00;
            end
        end
    end

    // -------------------------------------------------------------------------
    // Registered outputs
    // -------------------------------------------------------------------------
    // Every top output is registered; gating adds one cycle of latency.
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            coreMailboxBuffer      <= 8'h00;
            coreStatus             <= 8'h00;
            coreInputFullInterrupt <= 1'b0;
            keyboardInterrupt      <= 1'b0;
            cpuAddrMaskOut         <= 1'b0;
            alternateAddressGate   <= 1'b0; // see R19
            alternateResetOut      <= 1'b1; // see R16
            keyboardResetPin       <= 1'b1;
            keyboardClockOe        <= 1'b0; // see R10
            keyboardDataOe         <= 1'b0;
            mouseClockOe           <= 1'b0;
            mouseDataOe            <= 1'b0;
        end else begin
            coreMailboxBuffer      <= hostWriteBufQ; // see R02
            coreStatus             <= statusQ;
            coreInputFullInterrupt <= statusQ[`KBC_BIT_INFULL] & coreIbfIrqEnable; // see R06
            if (enableFlags) begin
                keyboardInterrupt <= keyboardIrqPortBit & statusQ[`KBC_BIT_OUTFULL]; // see R21 R01
            end else begin
                keyboardInterrupt <= keyboardIrqPortBit;
            end
            alternateAddressGate <= fastPortQ[1]; // see R13
            cpuAddrMaskOut       <= controllerGatePortBit | fastPortQ[1]; // see R18
            alternateResetOut    <= altPulseN; // see R14
            keyboardResetPin     <= (controllerResetPulse & (altPulseN | ~fastEn))
                                    ^ resetPolarityInvert; // see R17
            keyboardClockOe      <= 1'b0;
            keyboardDataOe       <= 1'b0;
            mouseClockOe         <= 1'b0;
            mouseDataOe          <= 1'b0;
        end
    end
endmodule // kbc_host_port
`default_nettype wire

// >>> bench/kbc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// -----------------------------------------------------------------------------
// Host CPU and system reset model
// -----------------------------------------------------------------------------
module kbc_host_model (
    // Clock.
    input  wire logic        clk,
    // System reset, active low.
    output var  logic        nrst,
    // Host I/O bus.
    output var  logic [15:0] hostAddr,
    output var  logic        hostRdN,
    output var  logic        hostWrN,
    output var  logic [7:0]  hostDataIn,
    input  wire logic [7:0]  hostDataOut,
    input  wire logic        hostDataOe
);
    localparam int STROBE_CYC = 8;
    localparam int RST_CYC    = 30;

    // Bus idle and reset asserted from time zero.
    initial begin
        nrst       = 1'b0;
        hostAddr   = 16'h0000;
        hostRdN    = 1'b1;
        hostWrN    = 1'b1;
        hostDataIn = 8'h00;
    end

    // Reset is held for 24 periods of 16 MHz, which is 30 cycles here.
    task automatic sys_reset();
        @(posedge clk);
        nrst <= 1'b0;
        repeat (RST_CYC) @(posedge clk);
        nrst <= 1'b1;
    endtask

    // One I/O cycle; strobe low and high long enough for the pin synchroniser.
    task automatic io_cycle(input logic [15:0] addr, input logic wr, input logic [7:0] din,
                            output logic [7:0] dout, output logic oe);
        @(posedge clk);
        hostAddr   <= addr;
        hostDataIn <= din;
        if (wr) begin
            hostWrN <= 1'b0;
        end else begin
            hostRdN <= 1'b0;
        end
        repeat (STROBE_CYC) @(posedge clk);
        dout = hostDataOut;
        oe   = hostDataOe;
        hostWrN    <= 1'b1;
        hostRdN    <= 1'b1;
        // Released data lines must not keep looking valid.
        hostDataIn <= ~din;
        repeat (STROBE_CYC) @(posedge clk);
    endtask
endmodule // kbc_host_model
`default_nettype wire

// >>> bench/kbc_host_port_checker.sv
`timescale 1ns/1ps
`default_nettype none
// -----------------------------------------------------------------------------
// Port behaviour checker
// -----------------------------------------------------------------------------
module kbc_host_port_checker (
    // Clock and reset.
    input wire logic        clk,
    input wire logic        nrst,
    // Host bus.
    input wire logic [15:0] hostAddr,
    input wire logic        hostWrN,
    input wire logic        hostDataOe,
    // Core side and configuration.
    input wire logic        coreDataWr,
    input wire logic        coreDataRd,
    input wire logic [7:0]  coreStatus,
    input wire logic        coreInputFullInterrupt,
    input wire logic        enableFlags,
    input wire logic        keyboardIrqPortBit,
    input wire logic        controllerGatePortBit,
    input wire logic        controllerResetPulse,
    input wire logic [7:0]  fastPortConfig,
    input wire logic        resetPolarityInvert,
    // System outputs.
    input wire logic        keyboardInterrupt,
    input wire logic        cpuAddrMaskOut,
    input wire logic        alternateAddressGate,
    input wire logic        alternateResetOut,
    input wire logic        keyboardResetPin
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    logic [9:0] lowCnt_q;
    logic [9:0] sinceWr_q;

    // Pulse width and time since the last write; the second saturates so idle time never wraps.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            lowCnt_q  <= 10'h000;
            sinceWr_q <= 10'h000;
        end else begin
            lowCnt_q  <= alternateResetOut ? 10'h000 : lowCnt_q + 10'h001;
            sinceWr_q <= !hostWrN ? 10'h000 : ((sinceWr_q == 10'h3ff) ? sinceWr_q : sinceWr_q + 10'h001);
        end
    end

    sequence s_gate_high;
        (controllerGatePortBit || alternateAddressGate) [*3];
    endsequence
    sequence s_gate_low;
        (!controllerGatePortBit && !alternateAddressGate) [*3];
    endsequence
    sequence s_rst_steady;
        (fastPortConfig[2] && !resetPolarityInvert && $stable(alternateResetOut) && $stable(controllerResetPulse)) [*3];
    endsequence

    a_mask_high: assert property (s_gate_high |-> cpuAddrMaskOut)
        else $error("address mask low while a gate source is high");
    a_mask_low: assert property (s_gate_low |-> !cpuAddrMaskOut)
        else $error("address mask high while both gate sources are low");
    a_reset_pin_and: assert property (s_rst_steady |-> keyboardResetPin == (alternateResetOut && controllerResetPulse))
        else $error("keyboard reset pin is not the AND of both reset pulses");
    a_pulse_width: assert property ($rose(alternateResetOut) |-> lowCnt_q >= 10'h078)
        else $error("alternate reset pulse shorter than 120 cycles");
    a_pulse_delay: assert property ($fell(alternateResetOut) |-> sinceWr_q >= 10'h10c)
        else $error("alternate reset pulse started too soon after the write");
    a_no_drive_off: assert property (hostDataOe |-> hostAddr == 16'h0060 || hostAddr == 16'h0064 || fastPortConfig[2])
        else $error("data bus driven for a disabled port");
    a_obf_set: assert property (coreDataWr |-> ##[1:2] coreStatus[0])
        else $error("output full flag not set by core write");
    a_ibf_clear: assert property (coreDataRd |-> ##[1:2] (!coreStatus[1] && !coreInputFullInterrupt))
        else $error("input full flag or interrupt not cleared by core read");
    a_keyboard_interrupt_forced: assert property ((enableFlags && !keyboardIrqPortBit) [*3] |-> !keyboardInterrupt)
        else $error("keyboard interrupt high while its port bit is clear");
endmodule // kbc_host_port_checker

bind kbc_host_port kbc_host_port_checker chk_u (.clk, .nrst, .hostAddr, .hostWrN, .hostDataOe, .coreDataWr,
    .coreDataRd, .coreStatus, .coreInputFullInterrupt, .enableFlags, .keyboardIrqPortBit, .controllerGatePortBit,
    .controllerResetPulse, .fastPortConfig, .resetPolarityInvert, .keyboardInterrupt, .cpuAddrMaskOut,
    .alternateAddressGate, .alternateResetOut, .keyboardResetPin);
`default_nettype wire

// >>> bench/tb_kbc_host_port.sv
`timescale 1ns/1ps
`default_nettype none
// -----------------------------------------------------------------------------
// Mailbox and fast gate port testbench
// -----------------------------------------------------------------------------
module tb_kbc_host_port;
    logic        clk, nrst, hostRdN, hostWrN, hostDataOe, oe;
    logic [15:0] hostAddr;
    logic [7:0]  hostDataIn, hostDataOut, coreDataIn, coreMailboxBuffer, coreStatus, fastPortConfig, rd;
    logic        coreDataWr, coreDataRd, coreStatusWr, coreInputFullInterrupt, coreIbfIrqEnable, enableFlags;
    logic        keyboardIrqPortBit, controllerGatePortBit, controllerResetPulse, resetPolarityInvert;
    logic        keyboardInterrupt, cpuAddrMaskOut, alternateAddressGate, alternateResetOut, keyboardResetPin;
    logic [3:0]  lineOe;
    int          n_errors, checked, n;

    kbc_host_port dut_u (.clk, .nrst, .hostAddr, .hostRdN, .hostWrN, .hostDataIn, .hostDataOut, .hostDataOe,
        .coreDataWr, .coreDataRd, .coreStatusWr, .coreDataIn, .coreMailboxBuffer, .coreStatus,
        .coreInputFullInterrupt, .coreIbfIrqEnable, .enableFlags, .keyboardIrqPortBit, .controllerGatePortBit,
        .controllerResetPulse, .fastPortConfig, .resetPolarityInvert, .keyboardInterrupt, .cpuAddrMaskOut,
        .alternateAddressGate, .alternateResetOut, .keyboardResetPin, .keyboardClockOe(lineOe[0]),
        .keyboardDataOe(lineOe[1]), .mouseClockOe(lineOe[2]), .mouseDataOe(lineOe[3]));
    kbc_host_model host_u (.clk, .nrst, .hostAddr, .hostRdN, .hostWrN, .hostDataIn, .hostDataOut, .hostDataOe);

    // Clock of 50 ns period.
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic end_sim();
        $display("checks %0d errors %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        host_u.io_cycle(a, 1'b1, d, rd, oe);
    endtask

    task automatic rdc(input logic [15:0] a);
        host_u.io_cycle(a, 1'b0, 8'h00, rd, oe);
    endtask

    // One-cycle core strobe: bit 0 data write, bit 1 data read, bit 2 status write.
    task automatic core_op(input logic [2:0] op, input logic [7:0] d);
        @(posedge clk);
        coreDataIn <= d;
        {coreStatusWr, coreDataRd, coreDataWr} <= op;
        @(posedge clk);
        {coreStatusWr, coreDataRd, coreDataWr} <= 3'h0;
        repeat (3) @(posedge clk);
    endtask

    // Bounded wait for the alternate reset level; a hang ends the run.
    task automatic wait_aro(input logic level, input int limit, output int cnt);
        cnt = 0;
        while (alternateResetOut !== level) begin
            @(posedge clk);
            cnt++;
            if (cnt > limit) begin
                n_errors++;
                $display("ERROR alternate reset wait expected %h seen %h", level, alternateResetOut);
                end_sim();
            end
        end
    endtask

    // Main sequence.
    initial begin
        {coreDataWr, coreDataRd, coreStatusWr, resetPolarityInvert, controllerGatePortBit} = 5'h00;
        {coreIbfIrqEnable, enableFlags, keyboardIrqPortBit, controllerResetPulse} = 4'hf;
        coreDataIn = 8'h00;
        fastPortConfig = 8'h00;
        n_errors = 0;
        checked = 0;
        host_u.sys_reset();
        check("status reset", coreStatus, 8'h00);
        check("line enables", lineOe, 4'h0);
        check("alt reset idle", alternateResetOut, 1'b1);
        check("alt gate reset", alternateAddressGate, 1'b0);
        wr(16'h0092, 8'h02);
        check("gate disabled", alternateAddressGate, 1'b0);
        rdc(16'h0092);
        check("oe disabled", oe, 1'b0);
        fastPortConfig <= 8'h04;
        rdc(16'h0092);
        check("port default", rd, 8'h24);
        check("oe enabled", oe, 1'b1);
        wr(16'h0092, 8'hfe);
        rdc(16'h0092);
        check("port fixed bits", rd, 8'h26);
        check("alt gate high", alternateAddressGate, 1'b1);
        check("mask by alt gate", cpuAddrMaskOut, 1'b1);
        wr(16'h0092, 8'h00);
        check("mask both low", cpuAddrMaskOut, 1'b0);
        controllerGatePortBit <= 1'b1;
        repeat (3) @(posedge clk);
        check("mask by port bit", cpuAddrMaskOut, 1'b1);
        wr(16'h0064, 8'ha5);
        check("status command", coreStatus & 8'h0b, 8'h0a);
        check("mailbox command", coreMailboxBuffer, 8'ha5);
        check("core irq", coreInputFullInterrupt, 1'b1);
        core_op(3'h2, 8'h00);
        check("status core read", coreStatus & 8'h0b, 8'h08);
        check("core irq clear", coreInputFullInterrupt, 1'b0);
        wr(16'h0060, 8'h3c);
        check("status data", coreStatus & 8'h0b, 8'h02);
        check("mailbox data", coreMailboxBuffer, 8'h3c);
        core_op(3'h1, 8'h5a);
        rdc(16'h0064);
        check("host status", rd & 8'h0b, 8'h03);
        check("kbd irq", keyboardInterrupt, 1'b1);
        rdc(16'h0060);
        check("host data", rd, 8'h5a);
        check("output full clear", coreStatus[0], 1'b0);
        check("kbd irq clear", keyboardInterrupt, 1'b0);
        keyboardIrqPortBit <= 1'b0;
        core_op(3'h1, 8'h11);
        check("kbd irq forced", keyboardInterrupt, 1'b0);
        enableFlags <= 1'b0;
        keyboardIrqPortBit <= 1'b1;
        repeat (3) @(posedge clk);
        check("kbd irq port level", keyboardInterrupt, 1'b1);
        enableFlags <= 1'b1;
        keyboardIrqPortBit <= 1'b0;
        resetPolarityInvert <= 1'b1;
        repeat (3) @(posedge clk);
        check("reset pin inverted", keyboardResetPin, 1'b0);
        resetPolarityInvert <= 1'b0;
        repeat (3) @(posedge clk);
        check("reset pin idle", keyboardResetPin, 1'b1);
        core_op(3'h4, 8'hff);
        rdc(16'h0064);
        check("user bits", rd & 8'hf4, 8'hf4);
        wr(16'h0092, 8'h01);
        wait_aro(1'b0, 400, n);
        check("pulse delay", n >= 268, 1'b1);
        check("reset pin in pulse", keyboardResetPin, 1'b0);
        wait_aro(1'b1, 300, n);
        check("pulse width", n >= 120, 1'b1);
        // A second write of 1 without clearing the bit must stay quiet.
        wr(16'h0092, 8'h01);
        n = 0;
        repeat (450) begin
            @(posedge clk);
            n += !alternateResetOut;
        end
        check("no retrigger", n, 16'h0000);
        host_u.sys_reset();
        rdc(16'h0092);
        check("bit0 cleared", rd, 8'h24);
        wr(16'h0092, 8'h01);
        wait_aro(1'b0, 400, n);
        check("pulse after reset", n >= 268, 1'b1);
        wait_aro(1'b1, 300, n);
        end_sim();
    end
endmodule // tb_kbc_host_port
`default_nettype wire
